//--- design/rtc_seconds_counter.sv
// Seconds counter of the real-time-clock timer with Avalon-MM register access
// Notes on behaviour
// RULE1 - Busy flag high throughout time recalculation
// RULE2 - Software discards time values read while busy
// RULE3 - Clock mode holds BCD seconds 00 to 59
// RULE4 - Units digit steps 0 to 9 per second
// RULE5 - Units carry adds one to tens digit
// RULE6 - Tens digit counts 0 to 5 only
// RULE7 - Compare mode reads full 8-bit count
// RULE8 - Stopped counter keeps its value; in clock mode a recalculation already started still commits after the stop
// RULE9 - Compare match clears counter to zero
// RULE10 - 59 wraps to 00 with minute carry
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rtc_seconds_counter #(
	parameter int unsigned TICK_CYCLES = rtc_seconds_pkg::SECOND_CYCLES
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Register bus
	input wire rtc_seconds_pkg::avl_req_s i_avl,
	output var rtc_seconds_pkg::avl_rsp_s o_avl,
	// Time status and events
	output logic o_update_in_progress,
	output logic o_minute_carry,
	output logic o_compare_match
);
	import rtc_seconds_pkg::*;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	// Bus answer state
	logic waitrequest;
	logic next_waitrequest;
	logic [31:0] readdata;
	logic next_readdata;
	logic [31:0] next_readdata_w;
	// Software registers
	logic [7:0] control;
	logic [7:0] next_control;
	logic [7:0] compare;
	logic [7:0] next_compare;
	// Counter, sequencer and events
	logic [7:0] count;
	logic [7:0] next_count;
	logic busy;
	logic next_busy;
	calc_state_e state;
	calc_state_e next_state;
	logic [1:0] calc_cnt;
	logic [1:0] next_calc_cnt;
	logic [7:0] pending;
	logic [7:0] next_pending;
	logic [31:0] prescale;
	logic [31:0] next_prescale;
	logic carry;
	logic next_carry;
	logic match;
	logic next_match;
	// Decoded strobes
	logic accept;
	logic wr_sec;
	logic wr_ctl;
	logic wr_cmp;
	logic mode_cmp;
	logic run;
	logic tick;

	// Advance BCD seconds by one; top bit flags the 59 to 00 wrap
	function automatic logic [7:0] bcd_step(input logic [6:0] v);
		logic [3:0] u;
		logic [2:0] t;
		u = v[3:0];
		t = v[6:4];
		if (u >= UNITS_MAX) begin
			u = 4'h0;
			if (t >= TENS_MAX) begin
				return {1'b1, 3'h0, 4'h0};
			end
			return {1'b0, 3'(t + 3'h1), u};
		end
		return {1'b0, t, 4'(u + 4'h1)};
	endfunction

	// Force illegal written digits to zero so clock mode stays in range
	function automatic logic [6:0] bcd_clean(input logic [6:0] v);
		logic [3:0] u;
		logic [2:0] t;
		u = (v[3:0] > UNITS_MAX) ? 4'h0 : v[3:0];
		t = (v[6:4] > TENS_MAX) ? 3'h0 : v[6:4];
		return {t, u};
	endfunction

	// Write strobe for one register, low byte lane only
	function automatic logic wr_hit(input avl_req_s r, input logic ws, input logic [23:0] off);
		return r.write && !ws && r.byteenable[0] && (r.address == off);
	endfunction

	// Bus decode
	assign accept = (i_avl.read || i_avl.write) && !waitrequest;
	assign wr_sec = wr_hit(i_avl, waitrequest, SECONDS_COUNT_OFFSET);
	assign wr_ctl = wr_hit(i_avl, waitrequest, CONTROL_OFFSET);
	assign wr_cmp = wr_hit(i_avl, waitrequest, COMPARE_OFFSET);
	assign mode_cmp = control[CTRL_MODE_BIT];
	assign run = control[CTRL_RUN_BIT];
	assign tick = run && (prescale == 32'(TICK_CYCLES - 1));
	// One assignment drives the whole answer so the output has a single driver
	assign o_avl = '{readdata: readdata, waitrequest: waitrequest};
	assign o_update_in_progress = busy;
	assign o_minute_carry = carry;
	assign o_compare_match = match;

	// Bus slave: one wait cycle, read data captured at the request edge
	always_comb begin
		next_waitrequest = !((i_avl.read || i_avl.write) && waitrequest);
		next_readdata = i_avl.read && waitrequest;
		next_readdata_w = readdata;
		next_control = control;
		next_compare = compare;
		if (next_readdata) begin
			unique case (i_avl.address)
				SECONDS_COUNT_OFFSET: begin
					// Whole count in compare mode, flag plus digits in clock mode
					next_readdata_w = mode_cmp ? {24'h0, count} : {24'h0, busy, count[6:0]}; // [RULE7] [RULE1]
				end
				CONTROL_OFFSET: next_readdata_w = {24'h0, control};
				COMPARE_OFFSET: next_readdata_w = {24'h0, compare};
				default: next_readdata_w = 32'h0;
			endcase
		end
		if (wr_ctl) begin
			next_control = {6'h0, i_avl.writedata[1:0]};
		end
		if (wr_cmp) begin
			next_compare = i_avl.writedata[7:0];
		end
	end

	// Bus slave registers
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			waitrequest <= 1'b1;
			readdata <= READDATA_RESET;
			control <= CONTROL_RESET;
			compare <= COMPARE_RESET;
		end else begin
			waitrequest <= next_waitrequest;
			readdata <= next_readdata_w;
			control <= next_control;
			compare <= next_compare;
		end
	end

	// Timekeeping: prescaler, recalculation sequencer, counter
	always_comb begin
		next_prescale = prescale;
		next_count = count;
		next_busy = busy;
		next_state = state;
		next_calc_cnt = calc_cnt;
		next_pending = pending;
		next_carry = 1'b0;
		next_match = 1'b0;
		// Prescaler halts with the run bit; the count then holds once any clock-mode recalculation in flight has committed
		if (run) begin
			next_prescale = tick ? 32'h0 : 32'(prescale + 32'h1); // [RULE8]
		end
		if (wr_sec) begin
			// Software load cancels any recalculation in flight
			next_count = mode_cmp ? i_avl.writedata[7:0] : {1'b0, bcd_clean(i_avl.writedata[6:0])};
			next_state = ST_IDLE;
			next_busy = 1'b0;
		end else if (wr_ctl && (i_avl.writedata[CTRL_MODE_BIT] != mode_cmp)) begin
			// Mode change starts from zero so each mode sees a legal value
			next_count = 8'h00;
			next_state = ST_IDLE;
			next_busy = 1'b0;
		end else if (mode_cmp) begin
			next_state = ST_IDLE;
			next_busy = 1'b0;
			if (tick) begin
				if (count == compare) begin
					next_count = 8'h00; // [RULE9]
					next_match = 1'b1;
				end else begin
					next_count = 8'(count + 8'h01); // [RULE7]
				end
			end
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (tick) begin
						next_pending = bcd_step(count[6:0]); // [RULE4] [RULE5] [RULE6]
						next_calc_cnt = 2'(UPDATE_CYCLES - 2'h1);
						next_busy = 1'b1; // [RULE1]
						next_state = ST_CALC;
					end
				end
				ST_CALC: begin
					if (calc_cnt == 2'h0) begin
						// Commit the new seconds and drop the flag together
						next_count = {1'b0, pending[6:0]}; // [RULE3]
						next_carry = pending[7]; // [RULE10]
						next_busy = 1'b0; // [RULE1]
						next_state = ST_IDLE;
					end else begin
						next_calc_cnt = 2'(calc_cnt - 2'h1);
					end
				end
			endcase
		end
	end

	// Timekeeping registers
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			prescale <= 32'h0;
			count <= SECONDS_RESET;
			busy <= 1'b0;
			state <= ST_IDLE;
			calc_cnt <= 2'h0;
			pending <= 8'h00;
			carry <= 1'b0;
			match <= 1'b0;
		end else begin
			prescale <= next_prescale;
			count <= next_count;
			busy <= next_busy;
			state <= next_state;
			calc_cnt <= next_calc_cnt;
			pending <= next_pending;
			carry <= next_carry;
			match <= next_match;
		end
	end

	// Helper: a clock-mode recalculation starts this cycle, undisturbed
	logic calc_start;
	assign calc_start = tick && !mode_cmp && (state == ST_IDLE) && !wr_sec && !wr_ctl;
	logic quiet;
	assign quiet = !wr_sec && !wr_ctl;

	// Busy rises with the recalculation while the shown seconds stay put
	chk_busy_calc_window: assert property ( // [RULE1]
		calc_start |=> busy && $stable(count)
	) else $error("busy flag not raised for recalculation");
	// Undisturbed, busy stands two cycles and falls at commit
	chk_busy_two_cycles: assert property ( // [RULE1]
		(calc_start ##1 quiet) |-> busy ##1 busy ##1 !busy
	) else $error("busy flag length wrong");
	// Compare mode never shows the flag
	chk_busy_clock_only: assert property ( // [RULE1]
		mode_cmp |-> !busy
	) else $error("busy flag up in compare mode");
	// Clock mode never leaves 00..59
	chk_bcd_range: assert property ( // [RULE3]
		!mode_cmp |-> (count[3:0] <= UNITS_MAX) && (count[6:4] <= TENS_MAX) && !count[7]
	) else $error("seconds out of BCD range");
	// Units advance by one at commit below nine
	chk_units_step: assert property ( // [RULE4]
		(state == ST_CALC && calc_cnt == 2'h0 && quiet && !mode_cmp && count[3:0] < UNITS_MAX)
		|=> (count[3:0] == 4'($past(count[3:0]) + 4'h1)) && (count[6:4] == $past(count[6:4]))
	) else $error("units digit did not step");
	// Units carry bumps the tens digit
	chk_tens_carry: assert property ( // [RULE5]
		(state == ST_CALC && calc_cnt == 2'h0 && quiet && !mode_cmp
		&& count[3:0] == UNITS_MAX && count[6:4] < TENS_MAX)
		|=> (count[3:0] == 4'h0) && (count[6:4] == 3'($past(count[6:4]) + 3'h1))
	) else $error("tens digit did not take carry");
	// Tens digit wraps after five
	chk_tens_limit: assert property ( // [RULE6]
		(state == ST_CALC && calc_cnt == 2'h0 && quiet && !mode_cmp && count[6:0] == 7'h59)
		|=> count[6:4] == 3'h0
	) else $error("tens digit passed five");
	// Compare-mode read returns the whole count
	chk_cmp_readback: assert property ( // [RULE7]
		(i_avl.read && waitrequest && mode_cmp && i_avl.address == SECONDS_COUNT_OFFSET)
		|=> readdata == {24'h0, $past(count)}
	) else $error("compare-mode read mismatch");
	// Compare mode counts as one plain byte, through the top bit
	chk_cmp_increment: assert property ( // [RULE7]
		(mode_cmp && tick && quiet && count != compare)
		|=> count == 8'($past(count) + 8'h01)
	) else $error("compare-mode count did not step");
	// Stopped counter holds its value in compare mode
	chk_hold_stopped: assert property ( // [RULE8]
		(mode_cmp && !run && quiet) |=> $stable(count)
	) else $error("stopped counter changed");
	// Compare match clears to zero
	chk_match_clear: assert property ( // [RULE9]
		(mode_cmp && tick && quiet && count == compare) |=> (count == 8'h00) && match
	) else $error("compare match did not clear");
	// Wrap from 59 carries to minutes for one cycle
	chk_wrap_carry: assert property ( // [RULE10]
		carry |-> (count == 8'h00) && $past(pending) == 8'h80 ##1 !carry
	) else $error("minute carry wrong");

	// Main scenarios
	cov_minute_wrap: cover property (carry);
	cov_compare_match: cover property (match ##1 mode_cmp);
	cov_read_while_busy: cover property (busy && accept && i_avl.read);
	cov_busy_window: cover property (calc_start ##1 busy ##1 busy ##1 !busy);
	cov_units_carry: cover property (busy && count[3:0] == UNITS_MAX);
endmodule
`default_nettype wire

//--- design/rtc_seconds_pkg.sv
// Constants, bus carriers and state types for the seconds counter
package rtc_seconds_pkg;
	// Bus geometry
	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	// Register byte addresses
	localparam logic [23:0] SECONDS_COUNT_OFFSET = 24'hffffa8;
	localparam logic [23:0] CONTROL_OFFSET = 24'hffffac;
	localparam logic [23:0] COMPARE_OFFSET = 24'hffffb0;
	// Field positions
	localparam int BUSY_BIT = 7;
	localparam int TENS_LSB = 4;
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_RUN_BIT = 1;
	// Values after reset
	localparam logic [7:0] SECONDS_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] COMPARE_RESET = 8'hff;
	localparam logic [31:0] READDATA_RESET = 32'h0000_0000;
	// Digit limits
	localparam logic [3:0] UNITS_MAX = 4'h9;
	localparam logic [2:0] TENS_MAX = 3'h5;
	// One second as a time, and its length in clock cycles
	localparam int unsigned SECOND_US = 1000000;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned SECOND_CYCLES = SECOND_US * CLK_MHZ;
	// Cycles for which a recalculation keeps the busy flag up
	localparam logic [1:0] UPDATE_CYCLES = 2'h2;

	// Avalon-MM request from the master
	typedef struct packed {
		logic [23:0] address;
		logic read;
		logic write;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} avl_req_s;

	// Avalon-MM answer to the master
	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} avl_rsp_s;

	// Recalculation sequencer
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_CALC
	} calc_state_e;
endpackage

//--- test/rtc_seconds_counter_bench.sv
// Self-checking testbench for the seconds counter through its Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
module rtc_seconds_counter_bench;
	import rtc_seconds_pkg::*;
	localparam int unsigned TICK = 8; // Short second keeps the run brief
	logic i_clk; // Bench clock
	logic i_reset_n; // Synchronous reset, active low
	avl_req_s i_avl; // Bus request driven here
	avl_rsp_s o_avl; // Bus answer
	logic o_update_in_progress; // Busy flag
	logic o_minute_carry; // Wrap pulse
	logic o_compare_match; // Match pulse
	int fails; // Mismatch count
	int comparisons; // Comparison count
	int cycles; // Hang guard
	int carries; // Minute carry pulses seen
	logic [31:0] busy_run; // Length of the current busy stretch
	logic [31:0] rd; // Last read data

	rtc_seconds_counter #(.TICK_CYCLES(TICK)) u_rtc_seconds_counter (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_avl(i_avl),
		.o_avl(o_avl),
		.o_update_in_progress(o_update_in_progress),
		.o_minute_carry(o_minute_carry),
		.o_compare_match(o_compare_match)
	);

	// Clock at 250 MHz
	always #2 i_clk = ~i_clk;

	// Compare and count; report a mismatch at once
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Print the verdict and stop
	task automatic give_verdict();
		if (fails == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// One bus cycle: hold until waitrequest is sampled low, take data there, then release
	task automatic bus(input logic wr, input logic [23:0] a, input logic [7:0] d,
		input logic [3:0] be);
		@(posedge i_clk);
		i_avl <= '{address: a, read: ~wr, write: wr, byteenable: be, writedata: {24'h0, d}};
		forever begin
			@(posedge i_clk);
			if (o_avl.waitrequest === 1'b0) break;
		end
		rd = o_avl.readdata;
		i_avl <= '0;
	endtask

	// Register write with the low byte enabled
	task automatic wr8(input logic [23:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask

	// Register read compared against a value
	task automatic rdchk(input string name, input logic [23:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00, 4'h1);
		check(name, rd, e);
	endtask

	// Wait for one recalculation to start and finish
	task automatic wait_update();
		int k;
		for (k = 0; k < 4 * TICK && o_update_in_progress !== 1'b1; k++) @(posedge i_clk);
		for (k = 0; k < 4 * TICK && o_update_in_progress !== 1'b0; k++) @(posedge i_clk);
	endtask

	// Reset values, unmapped place and a disabled byte lane
	task automatic test_reset_map();
		rdchk("seconds reset", SECONDS_COUNT_OFFSET, 32'h0000_0000);
		rdchk("compare reset", COMPARE_OFFSET, 32'h0000_00ff);
		rdchk("control reset", CONTROL_OFFSET, 32'h0000_0000);
		bus(1'b1, SECONDS_COUNT_OFFSET, 8'h12, 4'h0);
		rdchk("lane off write", SECONDS_COUNT_OFFSET, 32'h0000_0000);
		wr8(24'h000010, 8'h5a);
		rdchk("unmapped read", 24'h000010, 32'h0000_0000);
	endtask

	// Full minute of BCD seconds from 00 through 59 and back to 00
	task automatic test_clock_minute();
		int i;
		logic [7:0] e;
		// Top bit is not writable and an illegal units digit is forced to zero
		wr8(SECONDS_COUNT_OFFSET, 8'ha5);
		rdchk("top bit dropped", SECONDS_COUNT_OFFSET, 32'h0000_0025);
		wr8(SECONDS_COUNT_OFFSET, 8'h3c);
		rdchk("digit cleaned", SECONDS_COUNT_OFFSET, 32'h0000_0030);
		wr8(SECONDS_COUNT_OFFSET, 8'h00);
		wr8(CONTROL_OFFSET, 8'h02);
		for (i = 1; i <= 60; i++) begin
			// Digits are taken only once the flag has dropped
			wait_update();
			e = 8'(((i % 60) / 10) * 16 + (i % 60) % 10);
			rdchk("bcd seconds", SECONDS_COUNT_OFFSET, {24'h0, e});
		end
		wr8(CONTROL_OFFSET, 8'h00);
		check("minute carries", carries, 32'd1);
	endtask

	// Busy flag read back during a recalculation; digits read with it are thrown away
	task automatic test_busy_flag();
		int k;
		wr8(CONTROL_OFFSET, 8'h02);
		for (k = 0; k < 30; k++) begin
			bus(1'b0, SECONDS_COUNT_OFFSET, 8'h00, 4'h1);
			if (rd[7] === 1'b1) break;
		end
		check("busy bit read", {31'h0, rd[7]}, 32'h1);
		wr8(CONTROL_OFFSET, 8'h00);
	endtask

	// Output-compare mode: hold when stopped, full byte readback, clear on match
	task automatic test_compare();
		int k;
		wr8(CONTROL_OFFSET, 8'h01);
		rdchk("mode change clear", SECONDS_COUNT_OFFSET, 32'h0000_0000);
		wr8(SECONDS_COUNT_OFFSET, 8'h7e);
		wr8(COMPARE_OFFSET, 8'h81);
		repeat (4 * TICK) @(posedge i_clk);
		rdchk("stopped count", SECONDS_COUNT_OFFSET, 32'h0000_007e);
		wr8(CONTROL_OFFSET, 8'h03);
		for (k = 0; k < 40; k++) begin
			bus(1'b0, SECONDS_COUNT_OFFSET, 8'h00, 4'h1);
			if (rd === 32'h0000_0081) break;
		end
		check("full byte count", rd, 32'h0000_0081);
		for (k = 0; k < 3 * TICK && o_compare_match !== 1'b1; k++) @(posedge i_clk);
		check("match pulse", {31'h0, o_compare_match}, 32'h1);
		wr8(CONTROL_OFFSET, 8'h01);
		rdchk("cleared count", SECONDS_COUNT_OFFSET, 32'h0000_0000);
	endtask

	// Busy stretch length and carry pulses, watched throughout
	always @(posedge i_clk) begin
		if (i_reset_n === 1'b1) begin
			if (o_minute_carry === 1'b1) carries++;
			if (o_update_in_progress === 1'b1) begin
				busy_run = busy_run + 1;
			end else if (busy_run != 0) begin
				check("busy cycles", busy_run, {30'h0, UPDATE_CYCLES});
				busy_run = 0;
			end
		end
	end

	// Hang guard
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 4000) begin
			fails++;
			give_verdict();
		end
	end

	// Main sequence
	initial begin
		i_clk = 1'b0;
		i_reset_n = 1'b0;
		i_avl = '0;
		fails = 0;
		comparisons = 0;
		cycles = 0;
		carries = 0;
		busy_run = 0;
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1'b1;
		test_reset_map();
		test_clock_minute();
		test_busy_flag();
		test_compare();
		give_verdict();
	end
endmodule
`default_nettype wire
